// ---- usb_event_pkg.sv ----
/*
 * Constants for the USB event status register block: register offsets,
 * bit positions, reset values and write masks.
 * Assumes a 32-bit register bus with byte addresses, one word per register.
 */
package usb_event_pkg;

   // byte offsets of the registers
   localparam logic [7:0] ENABLE_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] EP_STATE_OFFSET = 8'h08;

   // status register bit positions
   localparam int BUS_BIT = 0;
   localparam int GENERAL_USB_BIT = 1;
   localparam int ATTACH_BIT = 2;
   localparam int WAKE_BIT = 3;
   localparam int EP_FLAG_LSB = 16;
   localparam int SETUP_BIT = 31;
   localparam int ENDPOINTS = 6;

   // enable register bit positions beyond the four interrupt enables
   localparam int WAKE_FUNC_BIT = 8;
   localparam int IN_NAK_BIT = 15;

   // endpoint state register: three bits of event kind per endpoint
   localparam int EP_KIND_LSB = 8;
   localparam int EP_KIND_WIDTH = 3;

   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
   localparam logic [31:0] EP_STATE_RESET = 32'h0000_0000;
   localparam logic [31:0] ENABLE_WRITE_MASK = 32'h0000_810F;
   localparam logic [31:0] STATUS_RESERVED_MASK = 32'h7FC0_FFF0;
   localparam logic [31:0] EP_STATE_RESERVED_MASK = 32'hFC00_00FF;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

   typedef logic [31:0] word_type;

endpackage : usb_event_pkg

// ---- sticky_flag.sv ----
/*
 * One sticky event flag: set by a hardware pulse, cleared by a clear pulse.
 * Assumes set and clear are synchronous to clk; set wins when both arrive.
 */
`timescale 1ns/100ps
module sticky_flag (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // event and clear
   input wire logic set,
   input wire logic clear,
   // state
   output logic flag
);
   import usb_event_pkg::*;

   typedef struct packed {
      logic flag;
   } flag_state_type;

   flag_state_type state;
   flag_state_type next_state;

   always_comb begin
      next_state = state;
      // an event in the clearing cycle must not be lost
      if (set) begin
         next_state.flag = 1'b1;
      end else if (clear) begin
         next_state.flag = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign flag = state.flag;

endmodule : sticky_flag

// ---- usb_event_status.sv ----
/*
 * USB event status register with its interrupt enable register and the
 * endpoint event-kind register, reached over an Avalon-MM slave port.
 * Assumes the USB engine delivers one-cycle event pulses synchronous to clk.
 */
// Design decision made here: the Avalon-MM slave port.
//
// Overview of operation
// - writing one clears any implemented status bit
// - setup event sets bit 31 until cleared
// - bits 16..21 flag events on endpoints 0..5
// - bit 1 write-one clears all endpoint flags
// - three-bit event kind per endpoint, from bit 8
// - wake-up event sets bit 3, write-one clears
// - attach or detach sets bit 2, write-one clears
// - four enable bits gate the interrupt sources
`timescale 1ns/100ps
module usb_event_status (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire usb_event_pkg::word_type writedata,
   output usb_event_pkg::word_type readdata,
   output logic waitrequest,
   // events from the usb engine
   input wire logic setup_event,
   input wire logic [5:0] endpoint_event,
   input wire logic [17:0] endpoint_event_kind,
   input wire logic bus_event,
   input wire logic wake_event,
   input wire logic attach_detach_event,
   // to the rest of the controller
   output logic wake_function_enable,
   output logic in_nak_enable,
   output logic irq
);
   import usb_event_pkg::*;

   typedef struct packed {
      logic ack;
      word_type readdata;
      word_type enable;
      word_type ep_state;
   } regs_type;

   regs_type state;
   regs_type next_state;

   logic request;
   logic accept;
   logic write_status;
   logic [5:0] endpoint_flags;
   logic setup_flag;
   logic bus_event_flag;
   logic wake_event_flag;
   logic attach_detach_flag;
   logic general_usb_event_flag;
   word_type status_word;

   // every check in this module, generate loops included, samples here
   default clocking main_clock @(posedge clk);
   endclocking
   default disable iff (rst);

   // one wait state per access: the answer is always the second cycle
   assign request = read || write;
   assign waitrequest = request && !state.ack;
   assign accept = request && state.ack;
   assign write_status = accept && write && (address == STATUS_OFFSET);

   sticky_flag setup_cell (
      .clk(clk),
      .rst(rst),
      .set(setup_event),
      .clear(write_status && writedata[SETUP_BIT]),
      .flag(setup_flag)
   );

   sticky_flag bus_cell (
      .clk(clk),
      .rst(rst),
      .set(bus_event),
      .clear(write_status && writedata[BUS_BIT]),
      .flag(bus_event_flag)
   );

   sticky_flag wake_cell (
      .clk(clk),
      .rst(rst),
      .set(wake_event),
      .clear(write_status && writedata[WAKE_BIT]),
      .flag(wake_event_flag)
   );

   sticky_flag attach_cell (
      .clk(clk),
      .rst(rst),
      .set(attach_detach_event),
      .clear(write_status && writedata[ATTACH_BIT]),
      .flag(attach_detach_flag)
   );

   genvar ep;
   generate
      for (ep = 0; ep < ENDPOINTS; ep++) begin : endpoint_slot
         sticky_flag endpoint_cell (
            .clk(clk),
            .rst(rst),
            .set(endpoint_event[ep]),
            // own bit or the general usb bit clears the flag
            .clear(write_status && (writedata[EP_FLAG_LSB + ep]
                   || writedata[GENERAL_USB_BIT])),
            .flag(endpoint_flags[ep])
         );

         ep_set_a: assert property (endpoint_event[ep] |=> endpoint_flags[ep])
            else $error("endpoint flag did not set after its event");

         ep_clear_a: assert property (
            write_status && writedata[EP_FLAG_LSB + ep] && !endpoint_event[ep]
            |=> !endpoint_flags[ep])
            else $error("endpoint flag not cleared by its own bit");

         ep_hold_a: assert property (
            endpoint_flags[ep]
            && !(write_status && (writedata[EP_FLAG_LSB + ep] || writedata[GENERAL_USB_BIT]))
            |=> endpoint_flags[ep])
            else $error("endpoint flag dropped without a clear");

         kind_capture_a: assert property (
            endpoint_event[ep]
            |=> state.ep_state[EP_KIND_LSB + EP_KIND_WIDTH * ep +: EP_KIND_WIDTH]
            == $past(endpoint_event_kind[EP_KIND_WIDTH * ep +: EP_KIND_WIDTH]))
            else $error("endpoint event kind not captured");
      end
   endgenerate

   // bit 1 reads as the summary of the endpoint flags
   assign general_usb_event_flag = |endpoint_flags;

   always_comb begin
      status_word = STATUS_RESET;
      status_word[SETUP_BIT] = setup_flag;
      status_word[EP_FLAG_LSB +: ENDPOINTS] = endpoint_flags;
      status_word[WAKE_BIT] = wake_event_flag;
      status_word[ATTACH_BIT] = attach_detach_flag;
      status_word[GENERAL_USB_BIT] = general_usb_event_flag;
      status_word[BUS_BIT] = bus_event_flag;
   end

   always_comb begin
      next_state = state;
      next_state.ack = waitrequest;
      // read data captured during the wait state, stands at the answer edge
      if (waitrequest && read) begin
         case (address)
            ENABLE_OFFSET: begin
               next_state.readdata = state.enable;
            end
            STATUS_OFFSET: begin
               next_state.readdata = status_word & ~STATUS_RESERVED_MASK;
            end
            EP_STATE_OFFSET: begin
               next_state.readdata = state.ep_state;
            end
            default: begin
               next_state.readdata = UNMAPPED_READ;
            end
         endcase
      end
      if (accept && write && (address == ENABLE_OFFSET)) begin
         next_state.enable = writedata & ENABLE_WRITE_MASK;
      end
      // latest event kind per endpoint, read-only to software
      for (int i = 0; i < ENDPOINTS; i++) begin
         if (endpoint_event[i]) begin
            next_state.ep_state[EP_KIND_LSB + EP_KIND_WIDTH * i +: EP_KIND_WIDTH] =
               endpoint_event_kind[EP_KIND_WIDTH * i +: EP_KIND_WIDTH];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state.ack <= 1'b0;
         state.readdata <= UNMAPPED_READ;
         state.enable <= ENABLE_RESET;
         state.ep_state <= EP_STATE_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign readdata = state.readdata;
   assign wake_function_enable = state.enable[WAKE_FUNC_BIT];
   assign in_nak_enable = state.enable[IN_NAK_BIT];

   // setup shares the usb enable, so it raises irq only while enable bit 1 is set
   assign irq = (bus_event_flag && state.enable[BUS_BIT])
      || ((general_usb_event_flag || setup_flag) && state.enable[GENERAL_USB_BIT])
      || (attach_detach_flag && state.enable[ATTACH_BIT])
      || (wake_event_flag && state.enable[WAKE_BIT]);

   sequence status_read_start;
      read && (address == STATUS_OFFSET) && waitrequest;
   endsequence

   sequence bus_answer;
      !waitrequest;
   endsequence

   sequence status_clear(int bit_index);
      write_status && writedata[bit_index];
   endsequence

   setup_set_a: assert property (setup_event |=> setup_flag)
      else $error("setup flag did not set");

   setup_hold_a: assert property (
      setup_flag && !(write_status && writedata[SETUP_BIT]) |=> setup_flag)
      else $error("setup flag dropped without a clear");

   setup_clear_a: assert property (
      status_clear(SETUP_BIT) and !setup_event |=> !setup_flag)
      else $error("setup flag not cleared by write one");

   bus_clear_a: assert property (
      status_clear(BUS_BIT) and !bus_event |=> !bus_event_flag)
      else $error("bus flag not cleared by write one");

   bus_hold_a: assert property (
      bus_event_flag && !(write_status && writedata[BUS_BIT]) |=> bus_event_flag)
      else $error("bus flag dropped without a clear");

   wake_set_a: assert property (wake_event |=> wake_event_flag)
      else $error("wake flag did not set");

   wake_clear_a: assert property (
      status_clear(WAKE_BIT) and !wake_event |=> !wake_event_flag)
      else $error("wake flag not cleared by write one");

   wake_hold_a: assert property (
      wake_event_flag && !(write_status && writedata[WAKE_BIT]) |=> wake_event_flag)
      else $error("wake flag dropped without a clear");

   attach_set_a: assert property (attach_detach_event |=> attach_detach_flag)
      else $error("attach flag did not set");

   attach_cycle_a: assert property (
      attach_detach_event ##1 status_clear(ATTACH_BIT) ##0 !attach_detach_event
      |=> !attach_detach_flag)
      else $error("attach flag set or clear wrong");

   attach_hold_a: assert property (
      attach_detach_flag && !(write_status && writedata[ATTACH_BIT]) |=> attach_detach_flag)
      else $error("attach flag dropped without a clear");

   bulk_clear_a: assert property (
      status_clear(GENERAL_USB_BIT) and (endpoint_event == 6'h00)
      |=> (endpoint_flags == 6'h00))
      else $error("general usb write did not clear endpoint flags");

   irq_gate_a: assert property ((state.enable[WAKE_BIT:BUS_BIT] == 4'h0) |-> !irq)
      else $error("interrupt raised with all enables cleared");

   irq_attach_a: assert property (
      attach_detach_flag && state.enable[ATTACH_BIT] |-> irq)
      else $error("enabled attach flag gives no interrupt");

   irq_wake_a: assert property (
      wake_event_flag && state.enable[WAKE_BIT] |-> irq)
      else $error("enabled wake flag gives no interrupt");

   irq_setup_a: assert property (
      setup_flag && state.enable[GENERAL_USB_BIT] |-> irq)
      else $error("enabled setup flag gives no interrupt");

   irq_quiet_a: assert property ((status_word == STATUS_RESET) |-> !irq)
      else $error("interrupt raised with no status bit set");

   enable_write_a: assert property (
      accept && write && (address == ENABLE_OFFSET)
      |=> state.enable == ($past(writedata) & ENABLE_WRITE_MASK))
      else $error("enable register write not applied");

   enable_reserved_a: assert property (
      (state.enable & ~ENABLE_WRITE_MASK) == 32'h0000_0000)
      else $error("reserved enable bits hold a one");

   ep_state_reserved_a: assert property (
      (state.ep_state & EP_STATE_RESERVED_MASK) == 32'h0000_0000)
      else $error("reserved endpoint state bits hold a one");

   reserved_zero_a: assert property (
      status_read_start ##1 bus_answer
      |-> (readdata & STATUS_RESERVED_MASK) == 32'h0000_0000)
      else $error("reserved status bits read nonzero");

   status_read_a: assert property (
      status_read_start ##1 bus_answer |-> readdata[SETUP_BIT] == $past(setup_flag))
      else $error("status read does not show setup flag");

   answer_time_a: assert property (
      request && waitrequest |=> !waitrequest)
      else $error("bus answer not on the second cycle");

   readdata_hold_a: assert property (
      !(waitrequest && read) |=> $stable(readdata))
      else $error("read data changed outside a read");

endmodule : usb_event_status

// ---- usb_engine_model.sv ----
/*
 usb engine stand-in: turns one bench request into one-cycle event pulses.
 assumes requests change by nonblocking assignment after a rising edge.
*/
`timescale 1ns/100ps
module usb_engine_model (
   // clock
   input wire logic clk,
   // request: {setup, endpoints 5..0, wake, attach, bus}
   input wire logic go,
   input wire logic [9:0] sel,
   input wire logic [17:0] kind,
   // event pulses
   output logic setup_event,
   output logic [5:0] endpoint_event,
   output logic [17:0] endpoint_event_kind,
   output logic bus_event,
   output logic wake_event,
   output logic attach_detach_event
);
   logic [9:0] pulse = 10'h000;
   logic [17:0] kind_out = 18'h3FFFF;
   assign {setup_event, endpoint_event, wake_event, attach_detach_event, bus_event} = pulse;
   assign endpoint_event_kind = kind_out;
   // kind means nothing outside its pulse, so never leave it stale
   always @(posedge clk) begin
      pulse <= go ? sel : 10'h000;
      kind_out <= go ? kind : ~kind;
   end
endmodule : usb_engine_model

// ---- test_usb_event_status.sv ----
/*
 self-checking bench for the usb event status block.
 waits on waitrequest for every access; event pulses come from usb_engine_model.
*/
`timescale 1ns/100ps
module test_usb_event_status;
   import usb_event_pkg::*;
   localparam logic [17:0] KIND = 18'h2C6A5;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   word_type writedata = 32'h0000_0000;
   word_type readdata;
   logic waitrequest, setup_event, bus_event, wake_event, attach_detach_event;
   logic wake_function_enable, in_nak_enable, irq, go = 1'b0;
   logic [5:0] endpoint_event;
   logic [17:0] endpoint_event_kind, kind = 18'h00000;
   logic [9:0] sel = 10'h000;
   int fails = 0;
   int total_checks = 0;
   logic [9:0] src [5] = '{10'h001, 10'h008, 10'h002, 10'h004, 10'h200};
   int en_bit [5] = '{0, 1, 2, 3, 1};
   word_type st [5] = '{32'h1, 32'h0001_0002, 32'h4, 32'h8, 32'h8000_0000};
   usb_event_status dut_u (.clk(clk), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .setup_event(setup_event),
      .endpoint_event(endpoint_event), .endpoint_event_kind(endpoint_event_kind),
      .bus_event(bus_event), .wake_event(wake_event),
      .attach_detach_event(attach_detach_event),
      .wake_function_enable(wake_function_enable), .in_nak_enable(in_nak_enable),
      .irq(irq));
   usb_engine_model engine_u (.clk(clk), .go(go), .sel(sel), .kind(kind),
      .setup_event(setup_event), .endpoint_event(endpoint_event),
      .endpoint_event_kind(endpoint_event_kind), .bus_event(bus_event),
      .wake_event(wake_event), .attach_detach_event(attach_detach_event));
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic check(input string name, input word_type seen, input word_type exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // request stands until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input word_type d,
         output word_type q);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      read <= ~wr;
      write <= wr;
      writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      if (waitrequest !== 1'b0) begin
         fails++;
         $display("[FAIL] waitrequest expected 0 seen %b", waitrequest);
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input word_type d);
      word_type q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input word_type exp);
      word_type q;
      bus(1'b0, a, 32'h0000_0000, q);
      check("readdata", q, exp);
   endtask : rd
   task automatic fire(input logic [9:0] s);
      @(posedge clk);
      go <= 1'b1;
      sel <= s;
      kind <= KIND;
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : fire
   task automatic irq_is(input logic exp);
      @(negedge clk);
      check("irq", {31'h0, irq}, {31'h0, exp});
   endtask : irq_is
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      end_of_test();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(ENABLE_OFFSET, ENABLE_RESET);
      rd(STATUS_OFFSET, STATUS_RESET);
      rd(EP_STATE_OFFSET, EP_STATE_RESET);
      wr(ENABLE_OFFSET, 32'hFFFF_FFFF);
      rd(ENABLE_OFFSET, ENABLE_WRITE_MASK);
      check("enables", {30'h0, wake_function_enable, in_nak_enable}, 32'h3);
      $display("test reset and enable done");
      for (int i = 0; i < 5; i++) begin
         wr(ENABLE_OFFSET, ENABLE_WRITE_MASK & ~(32'h1 << en_bit[i]));
         fire(src[i]);
         irq_is(1'b0);
         rd(STATUS_OFFSET, st[i]);
         wr(ENABLE_OFFSET, 32'h1 << en_bit[i]);
         irq_is(1'b1);
         wr(STATUS_OFFSET, 32'hFFFF_FFFF);
         irq_is(1'b0);
         rd(STATUS_OFFSET, 32'h0);
      end
      $display("test interrupt sources done");
      wr(ENABLE_OFFSET, 32'h0);
      fire(10'h3FF);
      irq_is(1'b0);
      rd(STATUS_OFFSET, 32'h803F_000F);
      rd(EP_STATE_OFFSET, {6'h0, KIND, 8'h00});
      wr(STATUS_OFFSET, STATUS_RESERVED_MASK | 32'h2);
      rd(STATUS_OFFSET, 32'h8000_000D);
      wr(STATUS_OFFSET, 32'h8000_0008);
      rd(STATUS_OFFSET, 32'h0000_0005);
      wr(STATUS_OFFSET, 32'h4);
      rd(STATUS_OFFSET, 32'h1);
      wr(STATUS_OFFSET, 32'h1);
      rd(STATUS_OFFSET, 32'h0);
      fire(10'h1F8);
      for (int i = 0; i < 6; i++) begin
         wr(STATUS_OFFSET, 32'h1 << (16 + i));
         rd(STATUS_OFFSET, ((32'h3F << (i + 1)) & 32'h3F) << 16 | (i < 5 ? 2 : 0));
      end
      $display("test clears done");
      wr(8'h10, 32'hFFFF_FFFF);
      rd(8'h10, UNMAPPED_READ);
      wr(EP_STATE_OFFSET, 32'h0);
      rd(EP_STATE_OFFSET, {6'h0, KIND, 8'h00});
      $display("test unmapped done");
      end_of_test();
   end
endmodule : test_usb_event_status
